// *** include/afc_pkg.sv ***
package afc_pkg;
    // register word indices; the byte address is the index times four
    localparam logic [7:0] IDX_CTL0   = 8'h00;
    localparam logic [7:0] IDX_CTL1   = 8'h01;
    localparam logic [7:0] IDX_FLOW   = 8'h02;
    localparam logic [7:0] IDX_IRQST  = 8'h03;
    localparam logic [7:0] IDX_IRQMSK = 8'h04;
    localparam logic [7:0] IDX_STATE  = 8'h05;
    localparam logic [7:0] IDX_CMD    = 8'h06;
    // control zero fields
    localparam int CTL0_EN     = 15;
    localparam int CTL0_WHALT  = 12;
    localparam int CTL0_PATH_H = 11;
    localparam int CTL0_PATH_L = 10;
    localparam int CTL0_STORE  = 9;
    localparam int CTL0_FMODE  = 8;
    // control one fields
    localparam int CTL1_CBUF   = 7;
    localparam int CTL1_RBUF   = 6;
    localparam int CTL1_SPEC   = 5;
    localparam int CTL1_AUTO   = 4;
    // flow control fields
    localparam int FLW_ABORT   = 3;
    localparam int FLW_RESTART = 2;
    localparam int FLW_TRIGGER_BIT    = 1;
    localparam int FLW_LOAD_OK_BIT    = 0;
    // interrupt status fields
    localparam int IRQ_RSTERR  = 0;
    localparam int IRQ_DONE    = 1;
    localparam int IRQ_AUTORS  = 2;
    localparam int IRQ_W       = 3;
    // access path encodings
    localparam logic [1:0] PATH_NONE = 2'h0;
    localparam logic [1:0] PATH_INT  = 2'h1;
    localparam logic [1:0] PATH_BUS  = 2'h2;
    localparam logic [1:0] PATH_BOTH = 2'h3;
    localparam logic [15:0] CTL0_RST = 16'h0000;
    localparam logic [7:0]  CTL1_RST = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    typedef enum logic [1:0] {
        AFC_IDLE = 2'b00,
        AFC_CONV = 2'b01,
        AFC_LAST = 2'b11
    } afc_state_e;
endpackage

// *** core/afc_top.sv ***
// Notes on behaviour
// - path select resets to zero, no access
// - path select grants internal, bus, or both
// - store off: abort discards result, no flag
// - store off: early restart flags error, sets abort
// - store on: abort stores result, updates info, no flag
// - store on: restart in last conversion no error
// - store on: early restart flags error, sets abort
// - flow mode zero restart, one trigger
// - command buffer mode, writable disabled or special
// - result buffer mode single or double
// - special access writable in special mode only
// - special access clears leaving special mode
// - special access lifts write restrictions
// - special access allows command write if unstarted
// - auto restart on stop or halted-wait exit
// - auto restart bit writable any time
// - wait halt stops at conversion boundary
`timescale 1ns/100ps
`default_nettype none
module afc_top #(
    parameter int CMD_W = 32
) (
    // clock and reset
    input  wire logic             CLK,
    input  wire logic             SRST,
    // ahb-lite slave
    input  wire logic             HSEL,
    input  wire logic [7:0]       HADDR,
    input  wire logic [1:0]       HTRANS,
    input  wire logic             HWRITE,
    input  wire logic [2:0]       HSIZE,
    input  wire logic [31:0]      HWDATA,
    input  wire logic             HREADY,
    output logic      [31:0]      HRDATA,
    output logic                  HREADYOUT,
    output logic                  HRESP,
    // internal flow-control interface
    input  wire logic             IF_WR,
    input  wire logic [3:0]       IF_FLOW,
    // chip mode and conversion engine status
    input  wire logic             SPECIAL_MODE,
    input  wire logic             STOP_EXIT,
    input  wire logic             WAIT_ENTRY,
    input  wire logic             WAIT_EXIT,
    input  wire logic             CONV_START,
    input  wire logic             CONV_END,
    input  wire logic             LIST_END,
    input  wire logic [CMD_W-1:0] CMD_LOAD,
    // conversion control outputs
    output logic      [3:0]       FLOW_BITS,
    output logic                  RESULT_STORE,
    output logic                  RESULT_DISCARD,
    output logic                  INFO_UPDATE,
    output logic                  HALT,
    output logic                  CMD_BUF_DOUBLE,
    output logic                  RES_BUF_DOUBLE,
    output logic                  TRIGGER_MODE,
    output logic      [CMD_W-1:0] CMD_REG,
    output logic                  IRQ
);
    logic [15:0]          ctl0;
    logic [7:0]           ctl1;
    logic [3:0]           flow;
    logic [afc_pkg::IRQ_W-1:0] irq_st;
    logic [afc_pkg::IRQ_W-1:0] irq_msk;
    logic [afc_pkg::IRQ_W-1:0] irq_set;
    afc_pkg::afc_state_e  st;
    logic                 dp_wr;
    logic [7:0]           dp_idx;
    logic                 halt_pend;
    logic                 wr_ctl0;
    logic                 wr_ctl1;
    logic                 wr_flow;
    logic                 wr_irqst;
    logic                 wr_irqmsk;
    logic                 wr_cmd;
    logic                 restart_evt;
    logic                 abort_evt;
    logic                 early_restart;
    logic                 cmd_started;
    logic                 bus_wr;
    logic                 int_wr;
    logic [3:0]           next_flow;
    logic                 enabled;
    logic                 lifted;
    logic                 store;

    // one data-phase write strobe per writable register, all decoded the same way
    function automatic logic wr_hit(input logic wr, input logic [7:0] idx,
                                    input logic [7:0] want);
        wr_hit = wr && (idx == want);
    endfunction

    function automatic logic path_on(input logic [1:0] sel, input logic [1:0] want);
        path_on = (sel & want) != 2'h0;
    endfunction

    // --------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // --------------------------------------------------------------
    // byte lanes are not decoded: only whole-word transfers are expected
    wire logic addr_ok = HSEL && HREADY &&
        (HTRANS == afc_pkg::HTRANS_NONSEQ || HTRANS == afc_pkg::HTRANS_SEQ);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            dp_wr  <= 1'b0;
            dp_idx <= 8'h00;
        end else begin
            dp_wr  <= addr_ok && HWRITE;
            if (addr_ok) begin
                dp_idx <= {2'h0, HADDR[7:2]};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            // every register answers at once, so no wait state and never an error
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            HRDATA <= 32'h0000_0000;
        end else begin
            if (addr_ok && !HWRITE) begin
                case ({2'h0, HADDR[7:2]})
                    afc_pkg::IDX_CTL0:   HRDATA <= {16'h0000, ctl0};
                    afc_pkg::IDX_CTL1:   HRDATA <= {24'h000000, ctl1};
                    afc_pkg::IDX_FLOW:   HRDATA <= {28'h0000000, flow};
                    afc_pkg::IDX_IRQST:  HRDATA <= {29'h0, irq_st};
                    afc_pkg::IDX_IRQMSK: HRDATA <= {29'h0, irq_msk};
                    afc_pkg::IDX_STATE:  HRDATA <= {30'h0, st};
                    default:             HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign enabled = ctl0[afc_pkg::CTL0_EN];
    assign lifted  = ctl1[afc_pkg::CTL1_SPEC];
    assign store   = ctl0[afc_pkg::CTL0_STORE];

    // --------------------------------------------------------------
    // register write strobes
    // --------------------------------------------------------------
    assign wr_ctl0   = wr_hit(dp_wr, dp_idx, afc_pkg::IDX_CTL0);
    assign wr_ctl1   = wr_hit(dp_wr, dp_idx, afc_pkg::IDX_CTL1);
    assign wr_flow   = wr_hit(dp_wr, dp_idx, afc_pkg::IDX_FLOW);
    assign wr_irqst  = wr_hit(dp_wr, dp_idx, afc_pkg::IDX_IRQST);
    assign wr_irqmsk = wr_hit(dp_wr, dp_idx, afc_pkg::IDX_IRQMSK);
    assign wr_cmd    = wr_hit(dp_wr, dp_idx, afc_pkg::IDX_CMD);

    // --------------------------------------------------------------
    // control registers
    // --------------------------------------------------------------
    // control zero takes every write; its users decide what a field may do
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctl0 <= afc_pkg::CTL0_RST;
        end else if (wr_ctl0) begin
            ctl0 <= HWDATA[15:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctl1 <= afc_pkg::CTL1_RST;
        end else begin
            if (wr_ctl1) begin
                if (!enabled || lifted) begin
                    ctl1[afc_pkg::CTL1_CBUF] <= HWDATA[afc_pkg::CTL1_CBUF];
                    ctl1[afc_pkg::CTL1_RBUF] <= HWDATA[afc_pkg::CTL1_RBUF];
                end
                if (SPECIAL_MODE) begin
                    ctl1[afc_pkg::CTL1_SPEC] <= HWDATA[afc_pkg::CTL1_SPEC];
                end
                ctl1[afc_pkg::CTL1_AUTO] <= HWDATA[afc_pkg::CTL1_AUTO];
            end
            if (!SPECIAL_MODE) begin
                ctl1[afc_pkg::CTL1_SPEC] <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // conversion tracking
    // --------------------------------------------------------------
    // clearing enable drops any conversion in flight
    always_ff @(posedge CLK) begin
        if (SRST || !enabled) begin
            st <= afc_pkg::AFC_IDLE;
        end else begin
            case (st)
                afc_pkg::AFC_IDLE: if (CONV_START) st <= LIST_END ? afc_pkg::AFC_LAST
                                                                  : afc_pkg::AFC_CONV;
                afc_pkg::AFC_CONV: if (CONV_END || abort_evt || restart_evt)
                                       st <= afc_pkg::AFC_IDLE;
                afc_pkg::AFC_LAST: if (CONV_END || abort_evt || restart_evt)
                                       st <= afc_pkg::AFC_IDLE;
                default:           st <= afc_pkg::AFC_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // flow control register
    // --------------------------------------------------------------
    assign bus_wr = wr_flow &&
                    path_on(ctl0[afc_pkg::CTL0_PATH_H:afc_pkg::CTL0_PATH_L],
                            afc_pkg::PATH_BUS);
    assign int_wr = IF_WR &&
                    path_on(ctl0[afc_pkg::CTL0_PATH_H:afc_pkg::CTL0_PATH_L],
                            afc_pkg::PATH_INT);

    // auto restart after low-power exit
    wire logic auto_rs = ctl1[afc_pkg::CTL1_AUTO] &&
        (STOP_EXIT || (WAIT_EXIT && ctl0[afc_pkg::CTL0_WHALT]));

    // the bus write is applied after the internal write, so it wins over the internal path
    always_comb begin
        next_flow = flow;
        if (int_wr) begin
            next_flow = IF_FLOW;
        end
        if (bus_wr) begin
            next_flow = HWDATA[3:0];
        end
        if (auto_rs) begin
            next_flow[afc_pkg::FLW_RESTART] = 1'b1;
        end
    end

    assign restart_evt = next_flow[afc_pkg::FLW_RESTART] && !flow[afc_pkg::FLW_RESTART];
    assign abort_evt   = next_flow[afc_pkg::FLW_ABORT] && !flow[afc_pkg::FLW_ABORT];
    // restart alone with the list unfinished: error unless storing in last conversion
    assign early_restart = restart_evt && !next_flow[afc_pkg::FLW_ABORT] &&
        !flow[afc_pkg::FLW_ABORT] && st != afc_pkg::AFC_IDLE &&
        !(store && st == afc_pkg::AFC_LAST);

    always_ff @(posedge CLK) begin
        if (SRST || !enabled) begin
            flow <= 4'h0;
        end else if (CONV_END && st == afc_pkg::AFC_IDLE) begin
            flow <= 4'h0;
        end else begin
            flow <= next_flow;
            if (early_restart) begin
                flow[afc_pkg::FLW_ABORT] <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // result handling on abort or restart
    // --------------------------------------------------------------
    wire logic cut = (abort_evt || restart_evt) && st != afc_pkg::AFC_IDLE;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            RESULT_STORE   <= 1'b0;
            RESULT_DISCARD <= 1'b0;
            INFO_UPDATE    <= 1'b0;
        end else begin
            // a cut conversion follows the store setting even if it ends in that cycle
            RESULT_STORE   <= (CONV_END && st != afc_pkg::AFC_IDLE && !cut) ||
                              (cut && store);
            INFO_UPDATE    <= cut && store;
            RESULT_DISCARD <= cut && !store;
        end
    end

    // --------------------------------------------------------------
    // wait halt and outputs
    // --------------------------------------------------------------
    // a wait entry in mid-conversion is held until the conversion boundary,
    // so a result is never cut off by the low-power request
    always_ff @(posedge CLK) begin
        if (SRST || WAIT_EXIT) begin
            HALT      <= 1'b0;
            halt_pend <= 1'b0;
        end else begin
            if (WAIT_ENTRY && ctl0[afc_pkg::CTL0_WHALT]) begin
                halt_pend <= 1'b1;
            end
            if ((halt_pend || (WAIT_ENTRY && ctl0[afc_pkg::CTL0_WHALT])) &&
                (st == afc_pkg::AFC_IDLE || CONV_END)) begin
                HALT      <= 1'b1;
                halt_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            FLOW_BITS      <= 4'h0;
            CMD_BUF_DOUBLE <= 1'b0;
            RES_BUF_DOUBLE <= 1'b0;
            TRIGGER_MODE   <= 1'b0;
        end else begin
            FLOW_BITS      <= flow;
            CMD_BUF_DOUBLE <= ctl1[afc_pkg::CTL1_CBUF];
            RES_BUF_DOUBLE <= ctl1[afc_pkg::CTL1_RBUF];
            TRIGGER_MODE   <= ctl0[afc_pkg::CTL0_FMODE];
        end
    end

    // --------------------------------------------------------------
    // current command register
    // --------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cmd_started <= 1'b0;
        end else if (CONV_START) begin
            cmd_started <= 1'b1;
        end else if (CONV_END || cut) begin
            cmd_started <= 1'b0;
        end
    end

    // a debug write loses against a start in the same cycle: the engine owns it
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CMD_REG <= '0;
        end else if (wr_cmd && lifted && !cmd_started && !CONV_START) begin
            CMD_REG <= HWDATA[CMD_W-1:0];
        end else if (!CONV_START && (CONV_END || cut)) begin
            CMD_REG <= CMD_LOAD;
        end
    end

    // --------------------------------------------------------------
    // interrupts: set wins over write-one clear
    // --------------------------------------------------------------
    assign irq_set = {auto_rs, CONV_END, early_restart};

    // set wins: an event in the clearing cycle stays visible
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_st <= '0;
        end else if (wr_irqst) begin
            irq_st <= (irq_st & ~HWDATA[afc_pkg::IRQ_W-1:0]) | irq_set;
        end else begin
            irq_st <= irq_st | irq_set;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_msk <= '0;
        end else if (wr_irqmsk) begin
            irq_msk <= HWDATA[afc_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_st & irq_msk);
        end
    end
endmodule
`default_nettype wire

// *** verification/afc_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module afc_props (
    // clock, reset and bus
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        HSEL,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // control outputs
    input wire logic [3:0]  FLOW_BITS,
    input wire logic        RESULT_STORE,
    input wire logic        RESULT_DISCARD,
    input wire logic        INFO_UPDATE,
    input wire logic        HALT,
    input wire logic        CMD_BUF_DOUBLE,
    input wire logic        RES_BUF_DOUBLE,
    input wire logic        TRIGGER_MODE,
    input wire logic        IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    logic wr;
    assign wr = HSEL && HTRANS[1] && HWRITE;
    AST_OKAY: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not okay");
    AST_RDHOLD: assert property (!(HSEL && HTRANS[1] && !HWRITE) |=> $stable(HRDATA))
        else $error("read data moved without a read");
    AST_RSTOUT: assert property (disable iff (1'b0) SRST |=> (FLOW_BITS == 4'h0) && !IRQ && !HALT)
        else $error("outputs not cleared by reset");
    AST_EXCL: assert property (!(RESULT_STORE && RESULT_DISCARD))
        else $error("result both stored and discarded");
    AST_INFO: assert property (INFO_UPDATE |-> RESULT_STORE)
        else $error("info update without store");
    AST_TMODE: assert property ($changed(TRIGGER_MODE) |-> $past(wr, 3))
        else $error("flow mode moved without a write");
    AST_CBUF: assert property ($changed(CMD_BUF_DOUBLE) |-> $past(wr, 3))
        else $error("command buffer mode moved without a write");
    AST_RBUF: assert property ($rose(RES_BUF_DOUBLE) || $fell(RES_BUF_DOUBLE) |-> $past(wr, 3))
        else $error("result buffer mode moved without a write");
endmodule
bind afc_top afc_props u_props (
    .CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FLOW_BITS(FLOW_BITS),
    .RESULT_STORE(RESULT_STORE), .RESULT_DISCARD(RESULT_DISCARD),
    .INFO_UPDATE(INFO_UPDATE), .HALT(HALT), .CMD_BUF_DOUBLE(CMD_BUF_DOUBLE),
    .RES_BUF_DOUBLE(RES_BUF_DOUBLE), .TRIGGER_MODE(TRIGGER_MODE), .IRQ(IRQ)
);
`default_nettype wire

// *** verification/afc_if_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module afc_if_model (
    // clock
    input  wire logic       clk,
    // internal flow-control path
    output logic            if_wr,
    output logic      [3:0] if_flow
);
    initial begin
        if_wr   = 1'b0;
        if_flow = 4'h5;
    end
    // released data shows the inverse so stale bits never look valid
    task automatic send(input logic [3:0] f);
        if_wr   <= 1'b1;
        if_flow <= f;
        @(posedge clk);
        if_wr   <= 1'b0;
        if_flow <= ~f;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** verification/adc_flow_and_buffer_config_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_flow_and_buffer_config_bench;
    logic        clk, srst, hsel, hwrite, sm, clr;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, q, cmd;
    logic [5:0]  ev;
    logic [3:0]  if_flow, flow_bits;
    logic        if_wr, hready, hresp, irq, halt, cbd, rbd, tmode, rs, rd, iu;
    logic [2:0]  seen;
    int          fails, n_tests;
    // ----
    // design and far side
    // ----
    afc_top u_dut (
        .CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IF_WR(if_wr),
        .IF_FLOW(if_flow), .SPECIAL_MODE(sm), .STOP_EXIT(ev[5]),
        .WAIT_ENTRY(ev[4]), .WAIT_EXIT(ev[3]), .CONV_START(ev[2]),
        .CONV_END(ev[1]), .LIST_END(ev[0]), .CMD_LOAD(32'h0),
        .FLOW_BITS(flow_bits), .RESULT_STORE(rs), .RESULT_DISCARD(rd),
        .INFO_UPDATE(iu), .HALT(halt), .CMD_BUF_DOUBLE(cbd),
        .RES_BUF_DOUBLE(rbd), .TRIGGER_MODE(tmode), .CMD_REG(cmd), .IRQ(irq)
    );
    afc_if_model u_ifm (.clk(clk), .if_wr(if_wr), .if_flow(if_flow));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // pulses are one cycle wide, so latch them for a later look
    always @(posedge clk) seen <= (clr ? 3'h0 : seen) | {iu, rs, rd};
    // ----
    // bus, event pulse and check tasks
    // ----
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= afc_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic pul(input logic [5:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 6'h00;
        @(posedge clk);
    endtask
    task automatic give_verdict;
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, sm, ev, clr} <= '0;
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rc(8'h00, 32'h0);
        wr(8'h04, 32'h20);
        rc(8'h04, 32'h0);
        for (int p = 0; p < 4; p++) begin
            wr(8'h00, 32'h0);
            wr(8'h00, 32'h8000 | (p << 10));
            u_ifm.send(4'h1);
            wr(8'h08, 32'h2);
            rc(8'h08, p[1] ? 32'h2 : {31'h0, p[0]});
        end
        sm <= 1'b1;
        wr(8'h04, 32'h20);
        wr(8'h04, 32'he0);
        wr(8'h18, 32'h1234_5678);
        pul(6'h04);
        chk(cmd, 32'h1234_5678);
        wr(8'h18, 32'h0000_0099);
        rc(8'h04, 32'he0);
        chk(cmd, 32'h1234_5678);
        pul(6'h02);
        chk(cmd, 32'h0);
        sm <= 1'b0;
        @(posedge clk);
        rc(8'h04, 32'hc0);
        wr(8'h04, 32'h10);
        rc(8'h04, 32'hd0);
        chk({30'h0, cbd, rbd}, 32'h3);
        wr(8'h00, 32'h100);
        wr(8'h04, 32'h0);
        rc(8'h04, 32'h0);
        chk({29'h0, cbd, rbd, tmode}, 32'h1);
        wr(8'h10, 32'h1);
        for (int k = 0; k < 3; k++) begin
            wr(8'h0c, 32'h7);
            wr(8'h00, 32'h0);
            wr(8'h00, k ? 32'h8a00 : 32'h8800);
            clr <= 1'b1;
            pul({5'h02, k == 1});
            clr <= 1'b0;
            wr(8'h08, 32'h4);
            rc(8'h00, k ? 32'h8a00 : 32'h8800);
            rc(8'h08, k == 1 ? 32'h4 : 32'hc);
            chk({28'h0, flow_bits}, k == 1 ? 32'h4 : 32'hc);
            rc(8'h0c, {31'h0, k != 1});
            chk({31'h0, irq}, {31'h0, k != 1});
            chk({29'h0, seen}, k ? 32'h6 : 32'h1);
        end
        wr(8'h10, 32'h0);
        rc(8'h0c, 32'h1);
        chk({31'h0, irq}, 32'h0);
        for (int a = 1; a >= 0; a--) begin
            wr(8'h00, 32'h0);
            wr(8'h00, 32'h8800);
            wr(8'h0c, 32'h7);
            wr(8'h04, a ? 32'h10 : 32'h0);
            pul(6'h20);
            rc(8'h04, a ? 32'h10 : 32'h0);
            rc(8'h0c, a ? 32'h4 : 32'h0);
        end
        wr(8'h00, 32'h9000);
        pul(6'h04);
        pul(6'h10);
        chk({31'h0, halt}, 32'h0);
        pul(6'h02);
        rc(8'h00, 32'h9000);
        chk({31'h0, halt}, 32'h1);
        give_verdict;
    end
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        give_verdict;
    end
endmodule
`default_nettype wire
